//--- inc/async_mem_map.vh
`ifndef ASYNC_MEM_MAP_VH
`define ASYNC_MEM_MAP_VH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_WAIT        12'h004
`define OFS_ADDR        12'h008
`define OFS_WDATA       12'h00C
`define OFS_RDATA       12'h010
`define OFS_STATUS      12'h014

// control fields
`define CTRL_GO_BIT     0
`define CTRL_WRITE_BIT  1
`define CTRL_BOOT_BIT   2
`define CTRL_ASYNC_BIT  3
`define CTRL_RESET      32'h0000_0008

// wait register fields
`define WAIT_CNT_LSB    0
`define WAIT_CNT_MSB    4
`define WAIT_HOLD_BIT   5
`define WAIT_IDLE_BIT   6
`define WAIT_RESET      32'h0000_0000

// status fields
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1

// strobe timing: output-clock period in clk_i cycles, setup in output-clock periods
`define OCLK_DIV        4'h2
`define SETUP_CYCLES    4'h1

`endif

//--- rtl/ack_sync.v
`timescale 1ns/1ns
`default_nettype none

module ack_sync (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire d_i,
    output reg  q_o
);

    reg meta;

    // two-stage synchroniser
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

`default_nettype wire

//--- rtl/async_ext_memory_master.v
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "async_mem_map.vh"

module async_ext_memory_master (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        input_clock_i,
    input  wire        ack_i,
    input  wire [31:0] data_i,
    output reg  [23:0] addr_o,
    output reg  [31:0] data_o,
    output reg         data_oe_o,
    output reg         memory_region_select_n_o,
    output reg         boot_memory_select_n_o,
    output reg         rd_n_o,
    output reg         wr_n_o,
    output reg         dma_grant_strobe_n_o
);

    localparam ST_IDLE  = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_WAIT  = 3'd2;
    localparam ST_ACK   = 3'd3;
    localparam ST_HOLD  = 3'd4;
    localparam ST_GAP   = 3'd5;

    reg        rst_meta;
    reg        rst_n;
    reg [31:0] ctrl;
    reg [31:0] wait_cfg;
    reg [23:0] addr_reg;
    reg [31:0] wdata;
    reg        done;
    reg [2:0]  state;
    reg [3:0]  div;
    reg [4:0]  wcnt;
    reg        is_wr;
    reg        ick_q;
    reg [31:0] din_meta;
    reg [31:0] din_s;
    wire       ick_s;
    wire       ack_s;
    wire       oclk_tick;
    wire       ick_rise;
    wire       busy;
    wire       apb_acc;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ack_sync u_ack_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (ack_i),
        .q_o     (ack_s)
    );

    ack_sync u_ick_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (input_clock_i),
        .q_o     (ick_s)
    );

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            ick_q <= 1'b0;
        else
            ick_q <= ick_s;
    end

    // read data bus through two flip-flops
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            din_meta <= 32'h00000000;
            din_s    <= 32'h00000000;
        end else begin
            din_meta <= data_i;
            din_s    <= din_meta;
        end
    end

    // ack sampled on input clock rise only
    assign ick_rise  = ick_s & ~ick_q;
    assign oclk_tick = (div == `OCLK_DIV - 4'h1);
    assign busy      = (state != ST_IDLE);
    assign apb_acc   = psel & penable & ~pready;

    // output-clock period divider
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            div <= 4'h0;
        else if (state == ST_IDLE || oclk_tick)
            div <= 4'h0;
        else
            div <= div + 4'h1;
    end

    // apb slave
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= `CTRL_RESET;
            wait_cfg <= `WAIT_RESET;
            addr_reg <= 24'h000000;
            wdata    <= 32'h00000000;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            pready  <= apb_acc;
            pslverr <= 1'b0;
            if (state == ST_SETUP)
                ctrl[`CTRL_GO_BIT] <= 1'b0;
            if (apb_acc) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `OFS_CTRL: begin
                        if (pwrite)
                            ctrl <= {28'h0000000, pwdata[3:0]};
                        else
                            prdata <= ctrl;
                    end
                    `OFS_WAIT: begin
                        if (pwrite)
                            wait_cfg <= {25'h0000000, pwdata[6:0]};
                        else
                            prdata <= wait_cfg;
                    end
                    `OFS_ADDR: begin
                        if (pwrite)
                            addr_reg <= pwdata[23:0];
                        else
                            prdata <= {8'h00, addr_reg};
                    end
                    `OFS_WDATA: begin
                        if (pwrite)
                            wdata <= pwdata;
                        else
                            prdata <= wdata;
                    end
                    `OFS_RDATA: begin
                        if (!pwrite)
                            prdata <= data_o;
                    end
                    `OFS_STATUS: begin
                        if (!pwrite)
                            prdata <= {30'h00000000, done, busy};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // access sequencer
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state                    <= ST_IDLE;
            wcnt                     <= 5'h00;
            is_wr                    <= 1'b0;
            done                     <= 1'b0;
            addr_o                   <= 24'h000000;
            data_o                   <= 32'h00000000;
            data_oe_o                <= 1'b0;
            memory_region_select_n_o <= 1'b1;
            boot_memory_select_n_o   <= 1'b1;
            rd_n_o                   <= 1'b1;
            wr_n_o                   <= 1'b1;
            dma_grant_strobe_n_o     <= 1'b1;
        end else begin
            if (apb_acc && paddr == `OFS_STATUS && !pwrite)
                done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (ctrl[`CTRL_GO_BIT] && ctrl[`CTRL_ASYNC_BIT]) begin
                        is_wr  <= ctrl[`CTRL_WRITE_BIT];
                        addr_o <= addr_reg;
                        // write data settles before strobe falls
                        if (ctrl[`CTRL_WRITE_BIT]) begin
                            data_o    <= wdata;
                            data_oe_o <= 1'b1;
                        end
                        // select first, strobe later
                        memory_region_select_n_o <= ctrl[`CTRL_BOOT_BIT];
                        boot_memory_select_n_o   <= ~ctrl[`CTRL_BOOT_BIT];
                        state  <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (oclk_tick) begin
                        wcnt <= wait_cfg[`WAIT_CNT_MSB:`WAIT_CNT_LSB];
                        if (is_wr) begin
                            wr_n_o <= 1'b0;
                        end else begin
                            rd_n_o <= 1'b0;
                        end
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // ack ignored while counting
                    if (oclk_tick) begin
                        if (wcnt == 5'h00)
                            state <= ST_ACK;
                        else
                            wcnt <= wcnt - 5'h01;
                    end
                end
                ST_ACK: begin
                    if (ick_rise && ack_s) begin
                        if (!is_wr)
                            data_o <= din_s;
                        rd_n_o <= 1'b1;
                        wr_n_o <= 1'b1;
                        done   <= 1'b1;
                        state  <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // hold selects, data_oe_o to next oclk_tick if WAIT_HOLD_BIT set, else release next cycle; address stays until next access
                    if (!wait_cfg[`WAIT_HOLD_BIT] || oclk_tick) begin
                        memory_region_select_n_o <= 1'b1;
                        boot_memory_select_n_o   <= 1'b1;
                        data_oe_o                <= 1'b0;
                        state                    <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // wait to next oclk_tick before next strobe if WAIT_HOLD_BIT or WAIT_IDLE_BIT set
                    if (!(wait_cfg[`WAIT_HOLD_BIT] | wait_cfg[`WAIT_IDLE_BIT]) || oclk_tick)
                        state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- verif/async_ext_memory_master_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module async_ext_memory_master_monitor (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        ack_i,
    input wire logic [23:0] addr_o,
    input wire logic [31:0] data_o,
    input wire logic        data_oe_o,
    input wire logic        memory_region_select_n_o,
    input wire logic        boot_memory_select_n_o,
    input wire logic        rd_n_o,
    input wire logic        wr_n_o
);
    wire sel = !memory_region_select_n_o || !boot_memory_select_n_o;
    wire stb = !rd_n_o || !wr_n_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_sel_lead; $rose(stb) |-> $past(sel, 2); endproperty
    property p_width; $rose(stb) |=> stb; endproperty
    property p_ack_end; $fell(stb) |-> $past(ack_i, 3); endproperty
    property p_addr; stb |-> sel && $stable(addr_o); endproperty
    property p_wdata; !wr_n_o |-> data_oe_o && $stable(data_o); endproperty
    property p_rd_float; !rd_n_o |-> !data_oe_o; endproperty
    property p_gap; $fell(stb) |-> !stb [*2]; endproperty
    property p_excl; !(!rd_n_o && !wr_n_o) && !(!memory_region_select_n_o
        && !boot_memory_select_n_o); endproperty
    a_sel_lead: assert property (p_sel_lead) else $error("select late");
    a_width: assert property (p_width) else $error("strobe short");
    a_ack_end: assert property (p_ack_end) else $error("end without ack");
    a_addr: assert property (p_addr) else $error("address moved");
    a_wdata: assert property (p_wdata) else $error("write data moved");
    a_rd_float: assert property (p_rd_float) else $error("bus driven on read");
    a_gap: assert property (p_gap) else $error("no strobe gap");
    a_excl: assert property (p_excl) else $error("strobes overlap");
    c_rd: cover property ($fell(rd_n_o));
    c_wr: cover property ($fell(wr_n_o));
    c_boot: cover property ($fell(boot_memory_select_n_o));
endmodule
`default_nettype wire

//--- verif/ext_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
    input  wire logic        clk_i,
    input  wire logic        input_clock_i,
    input  wire logic [3:0]  stall_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output wire logic        ack_o,
    output wire logic [31:0] rdata_o
);
    logic [31:0] mem [0:15];
    logic [31:0] last = 32'h0;
    logic [3:0]  cnt = 4'h0;
    logic        rdy = 1'b0;
    assign ack_o = rdy & !sel_n_i;
    assign rdata_o = !rd_n_i ? mem[addr_i[3:0]] : ~last;
    always @(posedge input_clock_i or posedge sel_n_i) begin
        if (sel_n_i) begin
            cnt <= 4'h0;
            rdy <= 1'b0;
        end else if (cnt == stall_i)
            rdy <= 1'b1;
        else
            cnt <= cnt + 4'h1;
    end
    always @(posedge clk_i) begin
        if (!wr_n_i)
            mem[addr_i[3:0]] <= wdata_i;
        if (!rd_n_i)
            last <= mem[addr_i[3:0]];
    end
endmodule
`default_nettype wire

//--- verif/async_ext_memory_master_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "async_mem_map.vh"
module async_ext_memory_master_test;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        input_clock_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  stall = 4'h0;
    wire  [31:0] prdata, data_i, data_o;
    wire  [23:0] addr_o;
    wire         pready, pslverr, ack_i, data_oe_o, rsel_n, bsel_n, rd_n, wr_n, dma_n;
    logic [31:0] q;
    logic        err_seen;
    logic [6:0]  cfg [4] = '{7'h00, 7'h23, 7'h42, 7'h61};
    logic [3:0]  stl [4] = '{4'h0, 4'h3, 4'h1, 4'h0};
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          slen = 0;
    always #25 clk_i = ~clk_i;
    always #35 input_clock_i = ~input_clock_i;
    async_ext_memory_master uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_clock_i(input_clock_i), .ack_i(ack_i), .data_i(data_i), .addr_o(addr_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .memory_region_select_n_o(rsel_n),
        .boot_memory_select_n_o(bsel_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .dma_grant_strobe_n_o(dma_n));
    ext_mem_model mem (.clk_i(clk_i), .input_clock_i(input_clock_i), .stall_i(stall),
        .sel_n_i(rsel_n & bsel_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr_o),
        .wdata_i(data_o), .ack_o(ack_i), .rdata_o(data_i));
    task automatic close_out;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic w, input logic b, input logic [6:0] wt,
                      input logic [3:0] a, input logic [31:0] d);
        int n;
        acc(1'b1, `OFS_WAIT, {25'h0, wt});
        acc(1'b1, `OFS_ADDR, {28'h0, a});
        acc(1'b1, `OFS_WDATA, d);
        slen = 0;
        acc(1'b1, `OFS_CTRL, {28'h0, 1'b1, b, w, 1'b1});
        n = 0;
        q = 32'h0;
        while (q[`STAT_DONE_BIT] !== 1'b1 && n < 200) begin
            acc(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end
        chk({31'h0, q[`STAT_DONE_BIT]}, 32'h1);
        chk({31'h0, slen >= 2 * (wt[4:0] + 1)}, 32'h1);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (!rd_n || !wr_n)
            slen <= slen + 1;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        acc(1'b0, `OFS_CTRL, 32'h0);
        chk(q, `CTRL_RESET);
        acc(1'b0, `OFS_WAIT, 32'h0);
        chk(q, `WAIT_RESET);
        acc(1'b0, 12'h020, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            stall <= stl[i];
            op(1'b1, i[0], cfg[i], i[3:0], 32'hA5C3_0F00 ^ i);
            op(1'b0, i[0], cfg[i], i[3:0], 32'h0);
            acc(1'b0, `OFS_RDATA, 32'h0);
            chk(q, 32'hA5C3_0F00 ^ i);
        end
        chk({31'h0, dma_n}, 32'h1);
        close_out();
    end
endmodule
bind async_ext_memory_master async_ext_memory_master_monitor mon (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ack_i(ack_i), .addr_o(addr_o), .data_o(data_o),
    .data_oe_o(data_oe_o), .memory_region_select_n_o(memory_region_select_n_o),
    .boot_memory_select_n_o(boot_memory_select_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
`default_nettype wire
